// *** rtl/prescaler_divider.sv ***
// binary prescaler with a selectable power-of-two output
`timescale 1ns/10ps
`default_nettype none
module prescaler_divider #(
    parameter int unsigned PRESC_WIDTH = timer_pkg::PRESC_BITS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // chain to the control logic
    timer_chain_if.div chain
);

    // ========================================================
    // divider storage
    // ========================================================
    logic [PRESC_WIDTH-1:0] presc_reg; // counts down from all ones
    logic [PRESC_WIDTH-1:0] tapMask;   // low bits that must be zero
    logic lowZero;                     // selected low bits all zero

    // mask of low bits for the selected division
    always_comb begin
        tapMask = '0;
        for (int i = 0; i < PRESC_WIDTH; i++) begin
            if (i < int'(chain.divSel)) begin
                tapMask[i] = 1'b1;
            end
        end
    end

    // a step falls when the low bits roll over, so 2^n ticks
    assign lowZero = ((presc_reg & tapMask) == '0);
    // zero select bypasses the divider
    assign chain.step = chain.tick & ~chain.clear & lowZero;

    // divider count, clear wins over a tick in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            presc_reg <= '1;
        end else if (chain.clear) begin
            presc_reg <= '1;
        end else if (chain.tick) begin
            presc_reg <= presc_reg - PRESC_WIDTH'(1);
        end
    end

endmodule : prescaler_divider
`default_nettype wire

// *** rtl/timer_chain_if.sv ***
// link between the control logic and the prescaler divider
`timescale 1ns/10ps
`default_nettype none
interface timer_chain_if;
    logic tick;      // one prescaler input event
    logic clear;     // reload prescaler with all ones
    logic [timer_pkg::DIV_W-1:0] divSel; // division as a power of two
    logic step;      // one counter decrement
    // control side
    modport ctrl (output tick, output clear, output divSel, input step);
    // divider side
    modport div (input tick, input clear, input divSel, output step);
endinterface : timer_chain_if
`default_nettype wire

// *** rtl/timer_pkg.sv ***
// shared constants and types for the prescaled timer control block
package timer_pkg;

    // ========================================================
    // register map: word index, byte address is four times it
    // ========================================================
    localparam logic [5:0] COUNT_INDEX = 6'h08;   // counter value, read only
    localparam logic [5:0] CONTROL_INDEX = 6'h09; // timer_control
    localparam logic [5:0] STATUS_INDEX = 6'h0a;  // sticky events, write one
    localparam logic [5:0] MASK_INDEX = 6'h0b;    // event enables

    // ========================================================
    // timer_control field positions
    // ========================================================
    localparam int unsigned CTL_REQ_BIT = 7;   // underflow_request
    localparam int unsigned CTL_MASK_BIT = 6;  // underflow_mask
    localparam int unsigned CTL_SRC_BIT = 5;   // clock_source_select
    localparam int unsigned CTL_EXT_BIT = 4;   // external_pin_enable
    localparam int unsigned CTL_CLR_BIT = 3;   // prescaler_clear
    localparam int unsigned CTL_DIV_MSB = 2;   // divider_select_hi
    localparam int unsigned CTL_DIV_LSB = 0;   // divider_select_lo
    localparam int unsigned DIV_W = 3;         // divider select width

    // ========================================================
    // option_byte field positions
    // ========================================================
    localparam int unsigned OPT_EMU_BIT = 6;   // emulation_select
    localparam int unsigned OPT_SRC_BIT = 5;   // fixed clock source
    localparam int unsigned OPT_EXT_BIT = 4;   // initial pin enable
    localparam int unsigned OPT_DIV_MSB = 2;   // fixed division, high
    localparam int unsigned OPT_DIV_LSB = 0;   // fixed division, low

    // ========================================================
    // event status bits
    // ========================================================
    localparam int unsigned EVT_UNDERFLOW_BIT = 0; // counter reached zero
    localparam int unsigned EVT_PIN_EDGE_BIT = 1;  // rising edge on pin
    localparam int unsigned EVT_W = 2;             // number of events

    // ========================================================
    // reset values and widths
    // ========================================================
    localparam logic REQ_RESET = 1'b0;             // request cleared
    localparam logic MASK_RESET = 1'b1;            // interrupt masked
    localparam logic [1:0] EVT_MASK_RESET = 2'h0;  // events disabled
    localparam logic [1:0] EVT_STATUS_RESET = 2'h0;
    localparam int unsigned PRESC_BITS = 7;        // 7-bit binary divider
    localparam int unsigned COUNT_BITS = 8;        // 8-bit counter

    // ========================================================
    // timing: cycles for the option byte to pass its synchroniser
    // ========================================================
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // strap capture sequence after reset
    typedef enum logic [2:0] {
        STRAP_WAIT = 3'b001,
        STRAP_LOAD = 3'b010,
        STRAP_RUN = 3'b100
    } strap_state_e;

endpackage : timer_pkg

// *** rtl/timer_prescaler_control.sv ***
// timer control register, clock select, prescaler and counter
//
// Operation
// - option bit 6 chooses emulation or software
// - emulation takes division and source from option
// - emulation forces pin enable to one
// - request flag sets when counter reaches zero
// - request clears on reset or a software write of zero
// - mask bit one blocks timer interrupt
// - mask set by reset, software writable
// - source bit picks pin or internal clock
// - source and enable pick four clock modes
// - clear bit write only, pulses prescaler clear
// - emulation clear per variant: active or inert
// - select bits divide by two to power
// - counter wraps zero to ones, reads harmless
// - reset loads ones, clears request, sets mask
// - external source advances on pin rising edge
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler_control #(
    parameter int unsigned COUNT_WIDTH = timer_pkg::COUNT_BITS,
    parameter int unsigned PRESC_WIDTH = timer_pkg::PRESC_BITS,
    // one: clear bit still works in emulation, zero: reads one, inert
    parameter bit EMU_CLEAR_ACTIVE = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // pins
    input wire logic timerPin,
    input wire logic [7:0] optionByte,
    // interrupts
    output logic timerIrq,
    output logic eventIrq
);

    // ========================================================
    // input synchronisers
    // ========================================================
    logic [7:0] optMeta_reg;  // first stage, option byte
    logic [7:0] optSync_reg;  // second stage, used by logic
    logic pinMeta_reg;        // first stage, timer pin
    logic pinSync_reg;        // second stage, used by logic
    logic pinLast_reg;        // previous synced pin level
    logic pinEdge;            // rising edge of the synced pin

    // two flops on the option byte, a static strap
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            optMeta_reg <= 8'h00;
            optSync_reg <= 8'h00;
        end else begin
            optMeta_reg <= optionByte;
            optSync_reg <= optMeta_reg;
        end
    end

    // two flops on the timer pin plus an edge history flop
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinMeta_reg <= 1'b0;
            pinSync_reg <= 1'b0;
            pinLast_reg <= 1'b0;
        end else begin
            pinMeta_reg <= timerPin;
            pinSync_reg <= pinMeta_reg;
            pinLast_reg <= pinSync_reg;
        end
    end

    // edge seen only on settled levels
    assign pinEdge = pinSync_reg & ~pinLast_reg;

    // ========================================================
    // strap capture after reset release
    // ========================================================
    timer_pkg::strap_state_e strapState_reg; // capture sequence
    logic [1:0] settleCnt_reg;               // synchroniser settle count

    // wait for the option byte to pass both flops, load once
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strapState_reg <= timer_pkg::STRAP_WAIT;
            settleCnt_reg <= 2'h0;
        end else begin
            case (strapState_reg)
                // count settle cycles
                timer_pkg::STRAP_WAIT: begin
                    if (settleCnt_reg == timer_pkg::STRAP_SETTLE) begin
                        strapState_reg <= timer_pkg::STRAP_LOAD;
                    end else begin
                        settleCnt_reg <= settleCnt_reg + 2'h1;
                    end
                end
                // one cycle of field loading
                timer_pkg::STRAP_LOAD: begin
                    strapState_reg <= timer_pkg::STRAP_RUN;
                end
                // normal operation
                timer_pkg::STRAP_RUN: begin
                    strapState_reg <= timer_pkg::STRAP_RUN;
                end
                // illegal code, recover
                default: begin
                    strapState_reg <= timer_pkg::STRAP_WAIT;
                end
            endcase
        end
    end

    // ========================================================
    // mode decode
    // ========================================================
    logic emuMode;                                // fixed-option emulation
    logic srcSel_reg;                             // clock_source_select
    logic extEn_reg;                              // external_pin_enable
    logic [timer_pkg::DIV_W-1:0] divSel_reg;      // divider select
    logic effSrc;                                 // source in use
    logic effExt;                                 // pin enable in use
    logic [timer_pkg::DIV_W-1:0] effDiv;          // division in use

    // emulation select decides which layout is live
    assign emuMode = optSync_reg[timer_pkg::OPT_EMU_BIT];

    // emulation reads fixed options, software uses register fields
    always_comb begin
        if (emuMode) begin
            effSrc = optSync_reg[timer_pkg::OPT_SRC_BIT];
            effExt = 1'b1;
            effDiv = optSync_reg[timer_pkg::OPT_DIV_MSB:
                timer_pkg::OPT_DIV_LSB];
        end else begin
            effSrc = srcSel_reg;
            effExt = extEn_reg;
            effDiv = divSel_reg;
        end
    end

    // ========================================================
    // avalon-mm handshake and decode
    // ========================================================
    logic ack_reg;      // second cycle of an access
    logic request;      // read or write pending
    logic accept;       // access completes at this edge
    logic [5:0] wordIdx; // word index of the address
    logic lowLane;      // byte lane holding the registers
    logic ctlWrite;     // write to timer_control
    logic statusWrite;  // write to event status
    logic maskWrite;    // write to event mask

    assign request = read | write;
    // one wait cycle, then the access is taken
    assign waitrequest = request & ~ack_reg;
    assign accept = request & ack_reg;
    assign wordIdx = address[7:2];
    assign lowLane = byteenable[0];
    assign ctlWrite = accept & write & lowLane &
        (wordIdx == timer_pkg::CONTROL_INDEX);
    assign statusWrite = accept & write & lowLane &
        (wordIdx == timer_pkg::STATUS_INDEX);
    assign maskWrite = accept & write & lowLane &
        (wordIdx == timer_pkg::MASK_INDEX);

    // ack flop is high for one cycle per access
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= request & ~ack_reg;
        end
    end

    // ========================================================
    // timer_control software fields
    // ========================================================
    // fields reload from the option byte once, then follow writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            srcSel_reg <= 1'b0;
            extEn_reg <= 1'b0;
            divSel_reg <= 3'h0;
        end else if (strapState_reg == timer_pkg::STRAP_LOAD) begin
            srcSel_reg <= optSync_reg[timer_pkg::OPT_SRC_BIT];
            extEn_reg <= optSync_reg[timer_pkg::OPT_EXT_BIT];
            divSel_reg <= optSync_reg[timer_pkg::OPT_DIV_MSB:
                timer_pkg::OPT_DIV_LSB];
        end else if (ctlWrite && !emuMode) begin
            // writes ignored in emulation
            srcSel_reg <= writedata[timer_pkg::CTL_SRC_BIT];
            extEn_reg <= writedata[timer_pkg::CTL_EXT_BIT];
            divSel_reg <= writedata[timer_pkg::CTL_DIV_MSB:
                timer_pkg::CTL_DIV_LSB];
        end
    end

    // ========================================================
    // prescaler clear pulse
    // ========================================================
    logic clrPulse_reg; // single cycle clear to the divider
    logic clrAllowed;   // clear bit has effect in this mode

    assign clrAllowed = ~emuMode | EMU_CLEAR_ACTIVE;

    // a written one makes exactly one pulse when clrAllowed
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clrPulse_reg <= 1'b0;
        end else begin
            clrPulse_reg <= ctlWrite & clrAllowed &
                writedata[timer_pkg::CTL_CLR_BIT];
        end
    end

    // ========================================================
    // clock source selection
    // ========================================================
    logic srcTick; // one prescaler input event this cycle

    // source and enable pick the divider input
    always_comb begin
        case ({effSrc, effExt})
            // internal phase two, every cycle
            2'b00: srcTick = 1'b1;
            // internal gated by pin level
            2'b01: srcTick = pinSync_reg;
            // no clock, timer stopped
            2'b10: srcTick = 1'b0;
            // external, rising pin edge
            2'b11: srcTick = pinEdge;
            default: srcTick = 1'b0;
        endcase
    end

    // ========================================================
    // prescaler divider
    // ========================================================
    timer_chain_if chain ();
    // no ticks before the strap fields are loaded
    assign chain.tick = srcTick & (strapState_reg == timer_pkg::STRAP_RUN);
    // a new division with the clear in the same write starts clean
    assign chain.clear = clrPulse_reg;
    assign chain.divSel = effDiv;

    prescaler_divider #(
        .PRESC_WIDTH(PRESC_WIDTH)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .reset(reset),
        .chain(chain)
    );

    // ========================================================
    // counter
    // ========================================================
    logic [COUNT_WIDTH-1:0] count_reg; // down counter
    logic underflowHit;                // counter goes to zero now

    assign underflowHit = chain.step &
        (count_reg == COUNT_WIDTH'(1));

    // decrement per divider step, wraps from zero to all ones
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_reg <= '1;
        end else if (chain.step) begin
            count_reg <= count_reg - COUNT_WIDTH'(1);
        end
    end

    // ========================================================
    // underflow request and mask
    // ========================================================
    logic req_reg;  // underflow_request
    logic mask_reg; // underflow_mask

    // set wins over a clearing write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_reg <= timer_pkg::REQ_RESET;
        end else if (underflowHit) begin
            req_reg <= 1'b1;
        end else if (ctlWrite && !writedata[timer_pkg::CTL_REQ_BIT]) begin
            req_reg <= 1'b0;
        end
    end

    // mask written in both modes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_reg <= timer_pkg::MASK_RESET;
        end else if (ctlWrite) begin
            mask_reg <= writedata[timer_pkg::CTL_MASK_BIT];
        end
    end

    // ========================================================
    // event status and mask
    // ========================================================
    logic [timer_pkg::EVT_W-1:0] evtStatus_reg; // sticky events
    logic [timer_pkg::EVT_W-1:0] evtMask_reg;   // event enables
    logic [timer_pkg::EVT_W-1:0] evtSet;        // events this cycle
    logic [timer_pkg::EVT_W-1:0] evtClr;        // written ones

    always_comb begin
        evtSet = '0;
        evtSet[timer_pkg::EVT_UNDERFLOW_BIT] = underflowHit;
        evtSet[timer_pkg::EVT_PIN_EDGE_BIT] = pinEdge;
    end

    assign evtClr = statusWrite ?
        writedata[timer_pkg::EVT_W-1:0] : '0;

    // write one clears, a new event in that cycle still sets
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            evtStatus_reg <= timer_pkg::EVT_STATUS_RESET;
        end else begin
            evtStatus_reg <= (evtStatus_reg & ~evtClr) | evtSet;
        end
    end

    // plain read-write enables
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            evtMask_reg <= timer_pkg::EVT_MASK_RESET;
        end else if (maskWrite) begin
            evtMask_reg <= writedata[timer_pkg::EVT_W-1:0];
        end
    end

    // ========================================================
    // read path
    // ========================================================
    logic [7:0] ctlRead;         // timer_control as software sees it
    logic [31:0] readMux;        // selected register
    logic [31:0] readdata_reg;   // held read data

    // emulation reads fixed fields as ones, clear bit per variant
    always_comb begin
        ctlRead = 8'h00;
        ctlRead[timer_pkg::CTL_REQ_BIT] = req_reg;
        ctlRead[timer_pkg::CTL_MASK_BIT] = mask_reg;
        if (emuMode) begin
            ctlRead[timer_pkg::CTL_SRC_BIT] = 1'b1;
            ctlRead[timer_pkg::CTL_EXT_BIT] = 1'b1;
            ctlRead[timer_pkg::CTL_CLR_BIT] = ~EMU_CLEAR_ACTIVE;
            ctlRead[timer_pkg::CTL_DIV_MSB:timer_pkg::CTL_DIV_LSB] = 3'h7;
        end else begin
            ctlRead[timer_pkg::CTL_SRC_BIT] = srcSel_reg;
            ctlRead[timer_pkg::CTL_EXT_BIT] = extEn_reg;
            ctlRead[timer_pkg::CTL_CLR_BIT] = 1'b0;
            ctlRead[timer_pkg::CTL_DIV_MSB:timer_pkg::CTL_DIV_LSB] =
                divSel_reg;
        end
    end

    // register select, unmapped words read zero
    always_comb begin
        readMux = 32'h0000_0000;
        case (wordIdx)
            // counter, reading leaves it running
            timer_pkg::COUNT_INDEX: readMux[COUNT_WIDTH-1:0] = count_reg;
            // control register
            timer_pkg::CONTROL_INDEX: readMux[7:0] = ctlRead;
            // sticky events
            timer_pkg::STATUS_INDEX: readMux[timer_pkg::EVT_W-1:0] =
                evtStatus_reg;
            // event enables
            timer_pkg::MASK_INDEX: readMux[timer_pkg::EVT_W-1:0] =
                evtMask_reg;
            default: readMux = 32'h0000_0000;
        endcase
    end

    // capture on the wait cycle so data stands when taken
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            readdata_reg <= 32'h0000_0000;
        end else if (read && !ack_reg) begin
            readdata_reg <= readMux;
        end
    end

    assign readdata = readdata_reg;

    // ========================================================
    // interrupt outputs
    // ========================================================
    // timer request reaches the core only when unmasked
    assign timerIrq = req_reg & ~mask_reg;
    // any enabled sticky event
    assign eventIrq = |(evtStatus_reg & evtMask_reg);

endmodule : timer_prescaler_control
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the timer control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0, write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h1;
    logic [7:0] optionByte = 8'h20;
    logic [31:0] readdata, q;
    logic waitrequest, timerPin, timerIrq, eventIrq;
    logic [7:0] c0;
    int failures = 0, tests_run = 0, k;
    // control write, read-back
    logic [7:0] rows [4][2] = '{'{8'h7f, 8'h77}, '{8'h2d, 8'h25},
        '{8'h62, 8'h62}, '{8'h15, 8'h15}};
    always #2.5 ref_clk = ~ref_clk;
    timer_prescaler_control i_dut (.ref_clk, .reset, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest,
        .timerPin, .optionByte, .timerIrq, .eventIrq);
    timer_pin_model i_pin (.ref_clk, .timerPin);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // one access, held until waitrequest low
    task automatic bus(input logic wr, input logic [5:0] i,
        input logic [7:0] d);
        int n;
        n = 0;
        address <= {i, 2'b00};
        writedata <= {24'h0, d};
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    // counter steps seen over gap cycles
    task automatic rate(input int gap, input logic [7:0] exp);
        bus(1'b0, timer_pkg::COUNT_INDEX, 8'h00);
        c0 = q[7:0];
        repeat (gap - 3) @(posedge ref_clk);
        bus(1'b0, timer_pkg::COUNT_INDEX, 8'h00);
        chk({24'h0, c0 - q[7:0]}, {24'h0, exp});
    endtask : rate
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        bus(1'b0, timer_pkg::CONTROL_INDEX, 8'h00);
        chk(q, 32'h60);
        foreach (rows[i]) begin
            bus(1'b1, timer_pkg::CONTROL_INDEX, rows[i][0]);
            bus(1'b0, timer_pkg::CONTROL_INDEX, 8'h00);
            chk(q, {24'h0, rows[i][1]});
        end
        bus(1'b0, timer_pkg::COUNT_INDEX, 8'h00);
        chk(q, 32'hff);
        byteenable <= 4'h0;
        bus(1'b1, timer_pkg::CONTROL_INDEX, 8'h00);
        byteenable <= 4'h1;
        bus(1'b0, timer_pkg::CONTROL_INDEX, 8'h00);
        chk(q, 32'h15);
        bus(1'b1, 6'h3f, 8'hff);
        bus(1'b0, 6'h3f, 8'h00);
        chk(q, 32'h0);
        $display("end of read-back test");
        for (int d = 0; d < 8; d++) begin
            bus(1'b1, timer_pkg::CONTROL_INDEX, 8'h48 | 8'(d));
            rate(16 << d, 8'h10);
        end
        bus(1'b1, timer_pkg::CONTROL_INDEX, 8'h08);
        k = 0;
        while (timerIrq !== 1'b1 && k < 300) begin
            @(negedge ref_clk);
            k++;
        end
        @(posedge ref_clk);
        chk({31'h0, timerIrq}, 32'h1);
        bus(1'b0, timer_pkg::COUNT_INDEX, 8'h00);
        chk({31'h0, q[7:0] > 8'hf0}, 32'h1);
        bus(1'b1, timer_pkg::CONTROL_INDEX, 8'he0);
        chk({31'h0, timerIrq}, 32'h0);
        bus(1'b0, timer_pkg::CONTROL_INDEX, 8'h00);
        chk(q, 32'he0);
        bus(1'b1, timer_pkg::CONTROL_INDEX, 8'h20);
        bus(1'b0, timer_pkg::CONTROL_INDEX, 8'h00);
        chk(q, 32'h20);
        $display("end of count test");
        bus(1'b1, timer_pkg::CONTROL_INDEX, 8'h78);
        bus(1'b0, timer_pkg::COUNT_INDEX, 8'h00);
        c0 = q[7:0];
        i_pin.pulse(2, 2, 5);
        repeat (4) @(posedge ref_clk);
        bus(1'b0, timer_pkg::COUNT_INDEX, 8'h00);
        chk({24'h0, c0 - q[7:0]}, 32'h5);
        bus(1'b1, timer_pkg::MASK_INDEX, 8'h03);
        chk({31'h0, eventIrq}, 32'h1);
        bus(1'b1, timer_pkg::STATUS_INDEX, 8'h03);
        chk({31'h0, eventIrq}, 32'h0);
        $display("end of pin test");
        optionByte <= 8'h41;
        reset <= 1'b1;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        bus(1'b0, timer_pkg::CONTROL_INDEX, 8'h00);
        chk(q, 32'h77);
        bus(1'b1, timer_pkg::CONTROL_INDEX, 8'h00);
        bus(1'b0, timer_pkg::CONTROL_INDEX, 8'h00);
        chk(q, 32'h37);
        i_pin.timerPin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rate(32, 8'h10);
        $display("end of emulation test");
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// *** testbench/timer_pin_model.sv ***
// external timer pin source
`timescale 1ns/10ps
`default_nettype none
module timer_pin_model (
    // clock
    input wire logic ref_clk,
    // pin
    output var logic timerPin
);
    initial timerPin = 1'b0;
    // n pulses of hi then lo cycles
    task automatic pulse(input int hi, input int lo, input int n);
        repeat (n) begin
            timerPin <= 1'b1;
            repeat (hi) @(posedge ref_clk);
            timerPin <= 1'b0;
            repeat (lo) @(posedge ref_clk);
        end
    endtask : pulse
endmodule : timer_pin_model
`default_nettype wire

// *** testbench/timer_prescaler_control_monitor.sv ***
// checker on the timer control block ports
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler_control_monitor #(
    parameter bit EMU_CLEAR_ACTIVE = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // pins and interrupts
    input wire logic [7:0] optionByte,
    input wire logic timerIrq,
    input wire logic eventIrq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic ctl; // access aimed at timer_control
    logic done; // access completing now
    assign ctl = address[7:2] == timer_pkg::CONTROL_INDEX;
    assign done = (read | write) & ~waitrequest;
    chk_wait_first: assert property ($rose(read | write) |-> waitrequest)
        else $error("no wait state");
    chk_wait_one: assert property ((read | write) && waitrequest
        |=> !waitrequest) else $error("wait too long");
    chk_idle_nowait: assert property (!(read | write) |-> !waitrequest)
        else $error("wait while idle");
    chk_reset_irq_low: assert property (disable iff (1'b0)
        reset |=> !timerIrq && !eventIrq) else $error("irq after reset");
    chk_clear_reads_zero: assert property (read && done && ctl
        && !optionByte[6] && !$past(optionByte[6], 4) |-> !readdata[3])
        else $error("clear bit read one");
    chk_emu_reads_ones: assert property (read && done && ctl
        && optionByte[6] && $past(optionByte[6], 4)
        |-> readdata[5:0] == {2'b11, !EMU_CLEAR_ACTIVE, 3'h7})
        else $error("emulation fields wrong");
    chk_mask_blocks_irq: assert property (write && done && ctl
        && byteenable[0] && writedata[6] |=> !timerIrq)
        else $error("masked irq high");
    chk_irq_fall_cause: assert property ($fell(timerIrq)
        |-> $past(reset) || $past(write && done && ctl))
        else $error("irq dropped alone");
    cover property ($rose(timerIrq));
    cover property ($rose(eventIrq));
    cover property (read && done && ctl && optionByte[6]);
endmodule : timer_prescaler_control_monitor
bind timer_prescaler_control timer_prescaler_control_monitor #(
    .EMU_CLEAR_ACTIVE(EMU_CLEAR_ACTIVE)) i_mon (.ref_clk, .reset,
    .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .optionByte, .timerIrq, .eventIrq);
`default_nettype wire
